/* design/tcrb_pkg.sv */
package tcrb_pkg;
    // Register access port shape
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int MODE_W = 3;
    localparam int NUM_PINS = 7;
    localparam int NUM_TS_EV = 6;
    localparam int NUM_GEN = 12;

    // Register offsets
    localparam logic [4:0] ADDR_IDENT = 5'h00;
    localparam logic [4:0] ADDR_CTRL1 = 5'h01;
    localparam logic [4:0] ADDR_CTRL2 = 5'h02;
    localparam logic [4:0] ADDR_PSTAT = 5'h03;
    localparam logic [4:0] ADDR_EVLAT = 5'h04;
    localparam logic [4:0] ADDR_EVEN = 5'h05;
    localparam logic [4:0] ADDR_LIVE = 5'h06;
    // Plain read-write words: io words 1..5, access command, clock, stamper, generator
    localparam logic [4:0] GEN_ADDR [NUM_GEN] = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
        5'h0E, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h1A};

    // Pin control one fields
    localparam int CTRL1_RST_BIT = 15;
    localparam int OUT1_LSB = 12;
    localparam int OUT2_LSB = 9;
    localparam int BIDIR1_LSB = 6;
    localparam int BIDIR2_LSB = 3;
    localparam int BIDIR3_LSB = 0;
    // Pin control two fields
    localparam int UPPER_POL_BIT = 13;
    localparam int LOWER_POL_BIT = 12;
    localparam int BIDIR7_LSB = 9;
    localparam int BIDIR6_LSB = 6;
    localparam int BIDIR5_LSB = 3;
    localparam int BIDIR4_LSB = 0;
    localparam logic [15:0] CTRL2_WR_MASK = 16'h3FFF;
    // Pin status and event fields
    localparam int PSTAT_LAT_LSB = 8;
    localparam int PSTAT_LIVE_LSB = 0;
    localparam int LOWER_PIN_COUNT = 3;
    localparam int EVLAT_ANY_BIT = 14;
    localparam int EVLAT_LSB = 8;
    localparam int EVEN_LSB = 8;
    localparam int LIVE_LOWLAT_BIT = 15;

    // Reset values and mode codes
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [2:0] MODE_HIZ = 3'h0;
    localparam logic [2:0] MODE_CLK125 = 3'h4;
endpackage

/* design/tcrb_event_latch.sv */
`timescale 1ns/100ps
module tcrb_event_latch #(
    parameter bit LATCH_LOW = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic soft_clr,
    input wire logic evt,
    input wire logic rd_clr,
    // Flag
    output logic flag_ff
);
    // Event beats the read clear so nothing is lost in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_ff <= LATCH_LOW;
        end else if (soft_clr) begin
            flag_ff <= LATCH_LOW;
        end else if (evt) begin
            flag_ff <= ~LATCH_LOW;
        end else if (rd_clr) begin
            flag_ff <= LATCH_LOW;
        end
    end
endmodule

/* design/tcrb_reg_bank.sv */
// Function
// - Writes never alter read-only fields
// - Self-clearing bit returns to zero alone
// - Latch-high bit sets, clears on read
// - Latch-low bit drops, restores on read
// - Identity word: revision over device code
// - Control one top bit resets device
// - Output-only pin selectors, reset zero
// - Bidir pins one-three selectors in control one
// - Bidir one selector strapped from pin
// - Control two bit13: pins four-seven edge
// - Control two bit12: pins one-three edge
// - Bidir pins seven-four selectors, reset zero
// - Pin latched status sets on chosen edge
`timescale 1ns/100ps
module tcrb_reg_bank #(
    parameter logic [3:0] REV_NUM = 4'h1, // Arbitrary value
    parameter logic [11:0] DEV_CODE = 12'h5A5 // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    // Pins and internal events
    input wire logic out_pin_one_in,
    input wire logic [6:0] pin_in,
    input wire logic [5:0] ts_event,
    input wire logic [5:0] ts_live,
    input wire logic low_event,
    // Device controls
    output logic soft_rst_ff,
    output logic [15:0] ctrl1_ff,
    output logic [15:0] ctrl2_ff,
    output logic [15:0] evt_en_ff,
    output logic [12*16-1:0] gen_regs_ff
);
    // Exact address match, shared by write and read paths
    function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
        hit = (a == off);
    endfunction

    // Index of a plain read-write word, NUM_GEN when none
    function automatic int gen_idx(input logic [4:0] a);
        gen_idx = tcrb_pkg::NUM_GEN;
        for (int k = 0; k < tcrb_pkg::NUM_GEN; k++) begin
            if (hit(a, tcrb_pkg::GEN_ADDR[k])) begin
                gen_idx = k;
            end
        end
    endfunction

    logic wr_ctrl1;
    logic wr_ctrl2;
    logic rd_pstat;
    logic rd_evlat;
    logic rd_live;
    logic strap_pend_ff;
    logic pin_vld_ff;
    logic [6:0] pin_prev_ff;
    logic [6:0] pin_evt;
    logic [6:0] pin_lat;
    logic [5:0] ts_lat;
    logic low_flag;
    logic [15:0] nxt_rdata;
    logic [2:0] strap_mode;

    assign wr_ctrl1 = reg_wr && hit(reg_addr, tcrb_pkg::ADDR_CTRL1);
    assign wr_ctrl2 = reg_wr && hit(reg_addr, tcrb_pkg::ADDR_CTRL2);
    assign rd_pstat = reg_rd && hit(reg_addr, tcrb_pkg::ADDR_PSTAT);
    assign rd_evlat = reg_rd && hit(reg_addr, tcrb_pkg::ADDR_EVLAT);
    assign rd_live = reg_rd && hit(reg_addr, tcrb_pkg::ADDR_LIVE);
    assign strap_mode = out_pin_one_in ? tcrb_pkg::MODE_CLK125 : tcrb_pkg::MODE_HIZ;

    // Soft reset pulse: one cycle, then the bit reads zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            soft_rst_ff <= 1'b0;
        end else begin
            soft_rst_ff <= wr_ctrl1 && reg_wdata[tcrb_pkg::CTRL1_RST_BIT];
        end
    end

    // Strap is sampled by a clock edge after release, never under reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_pend_ff <= 1'b1;
        end else begin
            strap_pend_ff <= 1'b0;
        end
    end

    // Pin control one; the reset bit itself is never stored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_ff <= tcrb_pkg::ZERO_WORD;
        end else if (strap_pend_ff || soft_rst_ff) begin
            ctrl1_ff <= tcrb_pkg::ZERO_WORD;
            ctrl1_ff[tcrb_pkg::BIDIR1_LSB +: tcrb_pkg::MODE_W] <= strap_mode;
        end else if (wr_ctrl1) begin
            ctrl1_ff <= {1'b0, reg_wdata[tcrb_pkg::CTRL1_RST_BIT-1:0]};
        end
    end

    // Pin control two; reserved top bits stay zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl2_ff <= tcrb_pkg::ZERO_WORD;
        end else if (soft_rst_ff) begin
            ctrl2_ff <= tcrb_pkg::ZERO_WORD;
        end else if (wr_ctrl2) begin
            ctrl2_ff <= reg_wdata & tcrb_pkg::CTRL2_WR_MASK;
        end
    end

    // Event enables and plain read-write words
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            evt_en_ff <= tcrb_pkg::ZERO_WORD;
            gen_regs_ff <= '0;
        end else if (soft_rst_ff) begin
            evt_en_ff <= tcrb_pkg::ZERO_WORD;
            gen_regs_ff <= '0;
        end else if (reg_wr) begin
            if (hit(reg_addr, tcrb_pkg::ADDR_EVEN)) begin
                evt_en_ff <= reg_wdata;
            end else if (gen_idx(reg_addr) < tcrb_pkg::NUM_GEN) begin
                gen_regs_ff[gen_idx(reg_addr)*16 +: 16] <= reg_wdata;
            end
        end
    end

    // Previous pin level; first sample after reset only primes it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_ff <= '0;
            pin_vld_ff <= 1'b0;
        end else begin
            pin_prev_ff <= pin_in;
            pin_vld_ff <= 1'b1;
        end
    end

    // Per-pin edge select and latched status
    genvar gi;
    generate
        for (gi = 0; gi < tcrb_pkg::NUM_PINS; gi++) begin : g_pin
            logic pol;
            if (gi < tcrb_pkg::LOWER_PIN_COUNT) begin : g_low
                assign pol = ctrl2_ff[tcrb_pkg::LOWER_POL_BIT];
            end else begin : g_up
                assign pol = ctrl2_ff[tcrb_pkg::UPPER_POL_BIT];
            end
            assign pin_evt[gi] = pin_vld_ff && (pin_in[gi] != pin_prev_ff[gi])
                && (pin_in[gi] == pol);
            tcrb_event_latch #(.LATCH_LOW(1'b0)) u_pin_lat (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .soft_clr(soft_rst_ff),
                .evt(pin_evt[gi]),
                .rd_clr(rd_pstat),
                .flag_ff(pin_lat[gi])
            );
        end
        for (gi = 0; gi < tcrb_pkg::NUM_TS_EV; gi++) begin : g_ts
            tcrb_event_latch #(.LATCH_LOW(1'b0)) u_ts_lat (
                .clk_sys(clk_sys),
                .rst_n(rst_n),
                .soft_clr(soft_rst_ff),
                .evt(ts_event[gi]),
                .rd_clr(rd_evlat),
                .flag_ff(ts_lat[gi])
            );
        end
    endgenerate

    // Latch-low flag in the live status word
    tcrb_event_latch #(.LATCH_LOW(1'b1)) u_low_lat (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .soft_clr(soft_rst_ff),
        .evt(low_event),
        .rd_clr(rd_live),
        .flag_ff(low_flag)
    );

    // Read mux; unmapped and reserved bits return zero
    always_comb begin
        nxt_rdata = tcrb_pkg::ZERO_WORD;
        if (hit(reg_addr, tcrb_pkg::ADDR_IDENT)) begin
            nxt_rdata = {REV_NUM, DEV_CODE};
        end else if (hit(reg_addr, tcrb_pkg::ADDR_CTRL1)) begin
            nxt_rdata = ctrl1_ff;
        end else if (hit(reg_addr, tcrb_pkg::ADDR_CTRL2)) begin
            nxt_rdata = ctrl2_ff;
        end else if (hit(reg_addr, tcrb_pkg::ADDR_PSTAT)) begin
            nxt_rdata[tcrb_pkg::PSTAT_LAT_LSB +: 7] = pin_lat;
            nxt_rdata[tcrb_pkg::PSTAT_LIVE_LSB +: 7] = pin_in;
        end else if (hit(reg_addr, tcrb_pkg::ADDR_EVLAT)) begin
            nxt_rdata[tcrb_pkg::EVLAT_LSB +: 6] = ts_lat;
            nxt_rdata[tcrb_pkg::EVLAT_ANY_BIT] =
                |(ts_lat & evt_en_ff[tcrb_pkg::EVEN_LSB +: 6]);
        end else if (hit(reg_addr, tcrb_pkg::ADDR_EVEN)) begin
            nxt_rdata = evt_en_ff;
        end else if (hit(reg_addr, tcrb_pkg::ADDR_LIVE)) begin
            nxt_rdata[5:0] = ts_live;
            nxt_rdata[tcrb_pkg::LIVE_LOWLAT_BIT] = low_flag;
        end else if (gen_idx(reg_addr) < tcrb_pkg::NUM_GEN) begin
            nxt_rdata = gen_regs_ff[gen_idx(reg_addr)*16 +: 16];
        end
    end

    // Read data lands one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= tcrb_pkg::ZERO_WORD;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    property p_sc_pulse;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_ctrl1 && reg_wdata[tcrb_pkg::CTRL1_RST_BIT])
            |=> soft_rst_ff ##1 (!soft_rst_ff && !ctrl1_ff[tcrb_pkg::CTRL1_RST_BIT]);
    endproperty
    a_sc_pulse: assert property (p_sc_pulse) else $error("soft reset not one pulse");

    property p_ctrl1_wr;
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_ctrl1 && !reg_wdata[15] && !soft_rst_ff && !strap_pend_ff)
            |=> ctrl1_ff == {1'b0, $past(reg_wdata[14:0])};
    endproperty
    a_ctrl1_wr: assert property (p_ctrl1_wr) else $error("control one write lost");

    property p_ident;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == tcrb_pkg::ADDR_IDENT)
            |=> reg_rvalid_ff && reg_rdata_ff == {REV_NUM, DEV_CODE};
    endproperty
    a_ident: assert property (p_ident) else $error("identity word wrong");

    property p_ctrl2_rsvd;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_ctrl2 |=> ctrl2_ff[15:14] == 2'h0;
    endproperty
    a_ctrl2_rsvd: assert property (p_ctrl2_rsvd) else $error("reserved bits written");

    property p_lh_set;
        @(posedge clk_sys) disable iff (!rst_n)
        (|pin_evt && !soft_rst_ff) |=> ((pin_lat & $past(pin_evt)) == $past(pin_evt));
    endproperty
    a_lh_set: assert property (p_lh_set) else $error("pin latch missed event");

    property p_lh_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_pstat && pin_evt == 7'h00) |=> pin_lat == 7'h00;
    endproperty
    a_lh_clear: assert property (p_lh_clear) else $error("pin latch not read-cleared");

    property p_ll_cycle;
        @(posedge clk_sys) disable iff (!rst_n)
        (low_event && !soft_rst_ff) |=> !low_flag;
    endproperty
    a_ll_cycle: assert property (p_ll_cycle) else $error("latch-low flag wrong");

    // Read without a competing event restores the idle one
    property p_ll_restore;
        @(posedge clk_sys) disable iff (!rst_n)
        (rd_live && !low_event && !soft_rst_ff) |=> low_flag;
    endproperty
    a_ll_restore: assert property (p_ll_restore) else $error("latch-low not restored");

    // Sampled reset level keeps the edge that releases reset out of the check
    property p_strap;
        @(posedge clk_sys) disable iff (!rst_n)
        (soft_rst_ff || (strap_pend_ff && rst_n))
            |=> ctrl1_ff[tcrb_pkg::BIDIR1_LSB +: tcrb_pkg::MODE_W]
                == ($past(out_pin_one_in) ? tcrb_pkg::MODE_CLK125 : tcrb_pkg::MODE_HIZ);
    endproperty
    a_strap: assert property (p_strap) else $error("strap selector wrong");

    property p_low_pol;
        @(posedge clk_sys) disable iff (!rst_n)
        (pin_vld_ff && ctrl2_ff[tcrb_pkg::LOWER_POL_BIT] && !pin_prev_ff[0] && pin_in[0]
            && !soft_rst_ff)
            |=> pin_lat[0];
    endproperty
    a_low_pol: assert property (p_low_pol) else $error("rising edge not latched");

    property p_unmapped;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && (reg_addr == 5'h07 || reg_addr == 5'h08 || reg_addr == 5'h0F))
            |=> reg_rdata_ff == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule

/* verif/tcrb_host_model.sv */
`timescale 1ns/100ps
// Host processor side of the register port
module tcrb_host_model (
    // Clock
    input wire logic clk_sys,
    // Request
    output logic [4:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    // Answer
    input wire logic [15:0] reg_rdata_ff,
    input wire logic reg_rvalid_ff
);
    // Idle bus at time zero
    initial begin
        reg_addr = 5'h00;
        reg_wdata = 16'hFFFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Write; idle data inverted so a stale word never looks valid
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        @(posedge clk_sys);
    endtask

    // Read; answer stands only in the cycle after the strobe is taken
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output bit ok);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        // Taken at this edge, before its own updates land
        ok = (reg_rvalid_ff === 1'b1);
        d = reg_rdata_ff;
    endtask
endmodule

/* verif/tcrb_reg_bank_tb.sv */
`timescale 1ns/100ps
module tcrb_reg_bank_tb;
    localparam logic [3:0] REVISION_NUMBER = 4'h3; // Arbitrary value
    localparam logic [11:0] DEV = 12'h6B2; // Arbitrary value
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata_ff;
    logic reg_rvalid_ff;
    logic out_pin_one_in = 1'b1;
    logic [6:0] pin_in = 7'h78;
    logic [5:0] ts_event = 6'h00;
    logic [5:0] ts_live = 6'h00;
    logic low_event = 1'b0;
    logic soft_rst_ff;
    logic [15:0] ctrl1_ff;
    logic [15:0] ctrl2_ff;
    logic [15:0] evt_en_ff;
    logic [191:0] gen_regs_ff;
    int errors = 0;
    int checks_done = 0;
    logic [15:0] rnd = 16'hD034;
    logic [15:0] got;
    logic [15:0] w;
    logic [15:0] gv [12];
    bit ok;

    // 50 MHz system clock
    always #10 clk_sys = ~clk_sys;

    tcrb_reg_bank #(.REV_NUM(REVISION_NUMBER), .DEV_CODE(DEV)) u_tcrb_reg_bank (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .reg_rvalid_ff(reg_rvalid_ff), .out_pin_one_in(out_pin_one_in), .pin_in(pin_in),
        .ts_event(ts_event), .ts_live(ts_live), .low_event(low_event),
        .soft_rst_ff(soft_rst_ff), .ctrl1_ff(ctrl1_ff), .ctrl2_ff(ctrl2_ff),
        .evt_en_ff(evt_en_ff), .gen_regs_ff(gen_regs_ff)
    );

    tcrb_host_model u_tcrb_host_model (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff)
    );

    // Pseudo-random words, fixed start for repeatable runs
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Offsets that hold a register
    function automatic bit mapped(input logic [4:0] a);
        return a inside {[5'h00:5'h06], [5'h09:5'h0E], [5'h10:5'h14], 5'h1A};
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Read and compare; a missing answer ends the run
    task automatic rdc(input logic [4:0] a, input logic [15:0] e);
        u_tcrb_host_model.rd(a, got, ok);
        if (!ok) begin
            errors++;
            $display("Error at %0t: no read answer", $time);
            final_report();
        end else begin
            chk(got, e);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rdc(5'h00, {REVISION_NUMBER, DEV});
        u_tcrb_host_model.wr(5'h00, 16'h0000);
        rdc(5'h00, {REVISION_NUMBER, DEV});
        rdc(5'h01, 16'h0100);
        chk(ctrl1_ff, 16'h0100);
        rdc(5'h02, 16'h0000);
        // Pin control words; reserved bits written as ones must read zero
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            w = (i == 0) ? 16'hFFFF : rnd;
            u_tcrb_host_model.wr(5'h01, w & 16'h7FFF);
            u_tcrb_host_model.wr(5'h02, w);
            rdc(5'h01, w & 16'h7FFF);
            rdc(5'h02, w & 16'h3FFF);
            chk(ctrl2_ff, w & 16'h3FFF);
        end
        // Plain words, then zeros to empty offsets must not alias onto them
        for (int k = 0; k < 12; k++) begin
            rnd = lfsr(rnd);
            gv[k] = rnd | 16'h0001;
            u_tcrb_host_model.wr(tcrb_pkg::GEN_ADDR[k], gv[k]);
        end
        for (int a = 0; a < 32; a++) begin
            if (!mapped(a[4:0])) u_tcrb_host_model.wr(a[4:0], 16'h0000);
        end
        for (int a = 0; a < 32; a++) begin
            if (!mapped(a[4:0])) rdc(a[4:0], 16'h0000);
        end
        for (int k = 0; k < 12; k++) begin
            rdc(tcrb_pkg::GEN_ADDR[k], gv[k]);
            chk(gen_regs_ff[k*16 +: 16], gv[k]);
        end
        // Pin edges: lower pins on rising, upper pins on falling
        u_tcrb_host_model.wr(5'h02, 16'h1000);
        pin_in <= 7'h07;
        repeat (3) @(posedge clk_sys);
        rdc(5'h03, 16'h7F07);
        rdc(5'h03, 16'h0007);
        pin_in <= 7'h78;
        repeat (3) @(posedge clk_sys);
        rdc(5'h03, 16'h0078);
        // Polarities swapped
        u_tcrb_host_model.wr(5'h02, 16'h2000);
        pin_in <= 7'h07;
        repeat (3) @(posedge clk_sys);
        rdc(5'h03, 16'h0007);
        pin_in <= 7'h78;
        repeat (3) @(posedge clk_sys);
        rdc(5'h03, 16'h7F78);
        // Time events, one source enabled
        u_tcrb_host_model.wr(5'h05, 16'h0800);
        rdc(5'h05, 16'h0800);
        chk(evt_en_ff, 16'h0800);
        ts_event <= 6'h2A;
        @(posedge clk_sys);
        ts_event <= 6'h00;
        @(posedge clk_sys);
        rdc(5'h04, 16'h6A00);
        rdc(5'h04, 16'h0000);
        // Latch-low bit beside the live status
        ts_live <= 6'h15;
        @(posedge clk_sys);
        rdc(5'h06, 16'h8015);
        low_event <= 1'b1;
        @(posedge clk_sys);
        low_event <= 1'b0;
        @(posedge clk_sys);
        rdc(5'h06, 16'h0015);
        rdc(5'h06, 16'h8015);
        // Soft reset with a pending event and strap low
        out_pin_one_in <= 1'b0;
        ts_event <= 6'h01;
        @(posedge clk_sys);
        ts_event <= 6'h00;
        fork
            u_tcrb_host_model.wr(5'h01, 16'h8000);
            begin
                @(posedge clk_sys);
                #1;
                chk({15'h0000, soft_rst_ff}, 16'h0001);
                @(posedge clk_sys);
                #1;
                chk({15'h0000, soft_rst_ff}, 16'h0000);
                chk(ctrl1_ff, 16'h0000);
            end
        join
        @(posedge clk_sys);
        rdc(5'h01, 16'h0000);
        rdc(tcrb_pkg::GEN_ADDR[0], 16'h0000);
        rdc(5'h04, 16'h0000);
        final_report();
    end
endmodule
